// [src/acs_params.svh]
// Offsets, field positions, reset values and timing counts of the block
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
// Register byte addresses
`define ACS_STATUS_OFF   32'hFFFF0500
`define ACS_MASK_OFF     32'hFFFF0504
`define ACS_MODE_OFF     32'hFFFF0508
`define ACS_CFG_OFF      32'hFFFF050C
`define ACS_PRI_RES_OFF  32'hFFFF0510
`define ACS_AUX_RES_OFF  32'hFFFF0514
`define ACS_TH_OFF       32'hFFFF0518
`define ACS_THV_OFF      32'hFFFF051C
`define ACS_TCL_OFF      32'hFFFF0520
`define ACS_ACC_OFF      32'hFFFF0524
`define ACS_ATH_OFF      32'hFFFF0528
// Reset values
`define ACS_STATUS_RST   16'h0000
`define ACS_MASK_RST     8'h00
`define ACS_MODE_RST     8'hA0
`define ACS_CFG_RST      8'h00
// Mode register fields
`define ACS_MODE_PRI_EN  0
`define ACS_MODE_AUX_EN  1
`define ACS_MODE_REFPWR  5
`define ACS_MODE_CLKFULL 7
// Configuration register fields
`define ACS_CFG_OVR_EN   2
`define ACS_CFG_CMP_LO   3
`define ACS_CFG_ACC_LO   5
// Status bit positions
`define ACS_ST_PRI_RDY   0
`define ACS_ST_AUX_RDY   1
`define ACS_ST_OVR       3
`define ACS_ST_THEX      4
`define ACS_ST_ATHEX     6
`define ACS_ST_PRI_ERR   12
`define ACS_ST_AUX_ERR   13
`define ACS_ST_CAL       15
// Full scale clamp codes
`define ACS_POS_FS       24'h7FFFFF
`define ACS_NEG_FS       24'h800000
// Overrange re-evaluation interval
`define ACS_CLK_PERIOD_NS 20
`define ACS_OVR_TIME_NS   125000
`define ACS_OVR_CYCLES    (`ACS_OVR_TIME_NS / `ACS_CLK_PERIOD_NS)
`endif

// [src/acs_pkg.sv]
// Types shared by the compare and accumulator logic
package acs_pkg;
    // Comparator operation from configuration bits 4:3
    typedef enum logic [1:0] {
        ACS_CMP_OFF,
        ACS_CMP_LEVEL,
        ACS_CMP_CNT_ABOVE,
        ACS_CMP_CNT_BELOW
    } acs_cmp_e;
    // Accumulator operation from configuration bits 6:5
    typedef enum logic [1:0] {
        ACS_ACC_OFF,
        ACS_ACC_ADD,
        ACS_ACC_SUB,
        ACS_ACC_HOLD
    } acs_acc_e;
endpackage

// [src/acs_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module acs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    // Asynchronous level in, synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    if (W < 1)
    begin : g_chk
        $error("acs_sync width must be at least one");
    end
    // First stage, read only by the second stage
    logic [W-1:0] meta;
    // ------------------------------------------------------------
    // Per-bit two flip-flop chain
    // ------------------------------------------------------------
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge sys_clk)
        begin
            if (!rst_b)
            begin
                meta[i] <= 1'b0;
                q[i]    <= 1'b0;
            end
            else
            begin
                meta[i] <= d[i];
                q[i]    <= meta[i];
            end
        end
    end
endmodule

// [src/acs_cmp.sv]
// Primary magnitude comparator with threshold counter
`timescale 1ns/10ps
module acs_cmp #(
    parameter int DW = 24,
    parameter int CW = 16
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // Accepted primary result
    input  wire logic              sample,
    input  wire logic [DW-1:0]     code,
    // Settings
    input  wire acs_pkg::acs_cmp_e mode,
    input  wire logic [DW-1:0]     thresh,
    input  wire logic [CW-1:0]     limit,
    // Flag and counter
    output logic                   hit,
    output logic      [CW-1:0]     count
);
    if (DW < 2 || CW < 1)
    begin : g_chk
        $error("acs_cmp widths too small");
    end
    logic [DW-1:0] mag;         // Sign-independent magnitude
    logic          counted;     // Result falls on the counted side
    logic          next_hit;
    logic [CW-1:0] next_count;
    // ------------------------------------------------------------
    // Next flag and count
    // ------------------------------------------------------------
    always_comb
    begin
        mag        = code[DW-1] ? DW'(~code + 1'b1) : code;
        counted    = (mode == acs_pkg::ACS_CMP_CNT_ABOVE) ? (mag > thresh)
                                                          : (mag < thresh);
        next_hit   = hit;
        next_count = count;
        unique case (mode)
            acs_pkg::ACS_CMP_OFF:
            begin
                next_hit   = 1'b0;
                next_count = '0;
            end
            acs_pkg::ACS_CMP_LEVEL:
            begin
                // Level compare on each result
                if (sample)
                    next_hit = (mag > thresh);
            end
            acs_pkg::ACS_CMP_CNT_ABOVE, acs_pkg::ACS_CMP_CNT_BELOW:
            begin
                // Count results, flag when limit reached
                if (sample && counted)
                begin
                    if (CW'(count + 1'b1) == limit)
                    begin
                        next_hit   = 1'b1;
                        next_count = '0;
                    end
                    else
                    begin
                        next_hit   = 1'b0;
                        next_count = CW'(count + 1'b1);
                    end
                end
                else if (sample)
                    next_hit = 1'b0;
            end
        endcase
    end
    // Register flag and count
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            hit   <= 1'b0;
            count <= '0;
        end
        else
        begin
            hit   <= next_hit;
            count <= next_count;
        end
    end
endmodule

// [src/acs_top.sv]
// Converter result handshake, compare, accumulate and status registers
// What this block does
// - Mode bit 7 clear slows converter clock
// - Reference power saving ignored with external reference
// - Flag magnitude above threshold when comparing
// - Threshold counter flags on reaching limit
// - Add or subtract results into 32-bit accumulator
// - Per-source mask; status register shows source
// - Primary result read clears all ready flags
// - Aux read clears ready when primary off
// - Result held until its ready flag clears
// - Core powered down: results always update
// - Calibration flag set; cleared by mode write
// - Aux range error flags and clamps result
// - In-range aux result clears aux error
// - Primary range error flags and clamps result
// - In-range primary result clears primary error
// - Accumulator flag follows accumulator above threshold
// - Bits 1 and 0 show results ready
// - Bit 4 shows comparator or counter hit
// - Mask mirrors low status bits, resets zero
// - Gross overrange flag re-evaluated each 125 us
`timescale 1ns/10ps
`include "acs_params.svh"
module acs_top #(
    parameter int OVR_PERIOD = `ACS_OVR_CYCLES,
    parameter int CW         = 16
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Memory-mapped register access
    input  wire logic [31:0] mmr_addr,
    input  wire logic        mmr_wr,
    input  wire logic        mmr_rd,
    input  wire logic [31:0] mmr_wdata,
    output logic      [31:0] mmr_rdata,
    // Primary converter results
    input  wire logic        pri_vld,
    input  wire logic [23:0] pri_code,
    input  wire logic        pri_over,
    input  wire logic        pri_under,
    // Auxiliary converter results
    input  wire logic        aux_vld,
    input  wire logic [23:0] aux_code,
    input  wire logic        aux_over,
    input  wire logic        aux_under,
    // System status inputs
    input  wire logic        cal_done,
    input  wire logic        gross_ovr_pin,
    input  wire logic        gain_change,
    input  wire logic        core_down,
    input  wire logic        ext_ref_sel,
    // Control and interrupt outputs
    output logic             conv_clk_slow,
    output logic             int_ref_sleep,
    output logic             irq
);
    if (OVR_PERIOD < 2 || CW < 1)
    begin : g_chk
        $error("acs_top parameter out of range");
    end
    localparam int TW = $clog2(OVR_PERIOD);
    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Address match against one register
    function automatic logic is_at(input logic [31:0] a,
                                   input logic [31:0] off);
        return a == off;
    endfunction
    // Clamp a code to full scale on range error
    function automatic logic [23:0] clamp(input logic [23:0] c,
                                          input logic        ov,
                                          input logic        un);
        if (ov)
            return `ACS_POS_FS;
        else if (un)
            return `ACS_NEG_FS;
        return c;
    endfunction
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]    mode;         // Converter mode register
    logic [7:0]    cfg;          // Converter configuration register
    logic [7:0]    mask;         // Interrupt mask
    logic [23:0]   th;           // Comparator threshold
    logic [CW-1:0] tcl;          // Counter limit
    logic [31:0]   ath;          // Accumulator threshold
    logic [31:0]   acc;          // Accumulator
    logic [23:0]   pri_data;     // Primary result register
    logic [23:0]   aux_data;     // Aux result register
    logic          rdy0;         // Primary result ready
    logic          rdy1;         // Aux result ready
    logic          err0;         // Primary range error
    logic          err1;         // Aux range error
    logic          cal;          // Calibration done
    logic          ovr;          // Gross overrange
    logic          athex;        // Accumulator above threshold
    logic [TW-1:0] tick_cnt;     // Overrange interval divider
    // Next values
    logic [7:0]    next_mode, next_cfg, next_mask;
    logic [23:0]   next_th, next_pri_data, next_aux_data;
    logic [CW-1:0] next_tcl;
    logic [31:0]   next_ath, next_acc, next_rdata;
    logic          next_rdy0, next_rdy1, next_err0, next_err1;
    logic          next_cal, next_ovr, next_athex, next_irq;
    logic          next_slow, next_sleep;
    logic [TW-1:0] next_tick_cnt;
    // Decoded strobes and helpers
    logic          ovr_sync;     // Synchronised gross overrange
    logic          tick;         // One pulse per interval
    logic          pri_take;     // Primary result written
    logic          aux_take;     // Aux result written
    logic          rdy_clr;      // Read clears ready flags
    logic          thex;         // Comparator hit
    logic [CW-1:0] thv;          // Threshold count
    logic [23:0]   pri_cl;       // Clamped primary code
    logic [31:0]   pri_ext;      // Sign-extended primary code
    logic [15:0]   sta;          // Status word
    acs_pkg::acs_acc_e acc_mode;
    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    // Gross overrange comparator arrives from the analog side
    acs_sync #(.W(1)) u_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .d       (gross_ovr_pin),
        .q       (ovr_sync)
    );
    // Magnitude comparator and threshold counter
    acs_cmp #(.DW(24), .CW(CW)) u_cmp (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .sample  (pri_take),
        .code    (pri_cl),
        .mode    (acs_pkg::acs_cmp_e'(cfg[`ACS_CFG_CMP_LO +: 2])),
        .thresh  (th),
        .limit   (tcl),
        .hit     (thex),
        .count   (thv)
    );
    // ------------------------------------------------------------
    // Status word and strobes
    // ------------------------------------------------------------
    always_comb
    begin
        sta = `ACS_STATUS_RST;   // Reserved bits stay zero
        sta[`ACS_ST_PRI_RDY] = rdy0;
        sta[`ACS_ST_AUX_RDY] = rdy1;
        sta[`ACS_ST_OVR]     = ovr;
        sta[`ACS_ST_THEX]    = thex;
        sta[`ACS_ST_ATHEX]   = athex;
        sta[`ACS_ST_PRI_ERR] = err0;
        sta[`ACS_ST_AUX_ERR] = err1;
        sta[`ACS_ST_CAL]     = cal;
        // Read of primary, or aux with primary off, clears ready
        rdy_clr  = mmr_rd && (is_at(mmr_addr, `ACS_PRI_RES_OFF)
                   || (is_at(mmr_addr, `ACS_AUX_RES_OFF)
                       && !mode[`ACS_MODE_PRI_EN]));
        // New results only land once ready is cleared, or while core is down
        pri_take = pri_vld && mode[`ACS_MODE_PRI_EN]
                   && (!rdy0 || rdy_clr || core_down);
        aux_take = aux_vld && mode[`ACS_MODE_AUX_EN]
                   && (!rdy1 || rdy_clr || core_down);
        pri_cl   = clamp(pri_code, pri_over, pri_under);
        pri_ext  = {{8{pri_cl[23]}}, pri_cl};
        acc_mode = acs_pkg::acs_acc_e'(cfg[`ACS_CFG_ACC_LO +: 2]);
        tick     = (tick_cnt == TW'(OVR_PERIOD - 1));
    end
    // ------------------------------------------------------------
    // Next-state logic for registers and flags
    // ------------------------------------------------------------
    always_comb
    begin
        next_mode     = mode;
        next_cfg      = cfg;
        next_mask     = mask;
        next_th       = th;
        next_tcl      = tcl;
        next_ath      = ath;
        next_acc      = acc;
        next_pri_data = pri_data;
        next_aux_data = aux_data;
        next_tick_cnt = tick ? '0 : TW'(tick_cnt + 1'b1);
        // Software writes; status and results are read only
        if (mmr_wr)
        begin
            if (is_at(mmr_addr, `ACS_MODE_OFF))
                next_mode = mmr_wdata[7:0];
            if (is_at(mmr_addr, `ACS_CFG_OFF))
                next_cfg = mmr_wdata[7:0];
            if (is_at(mmr_addr, `ACS_MASK_OFF))
                next_mask = mmr_wdata[7:0];
            if (is_at(mmr_addr, `ACS_TH_OFF))
                next_th = mmr_wdata[23:0];
            if (is_at(mmr_addr, `ACS_TCL_OFF))
                next_tcl = mmr_wdata[CW-1:0];
            if (is_at(mmr_addr, `ACS_ATH_OFF))
                next_ath = mmr_wdata;
        end
        // Result registers
        if (pri_take)
            next_pri_data = pri_cl;
        if (aux_take)
            next_aux_data = clamp(aux_code, aux_over, aux_under);
        // Accumulator
        unique case (acc_mode)
            acs_pkg::ACS_ACC_OFF:  next_acc = '0;
            acs_pkg::ACS_ACC_ADD:  if (pri_take) next_acc = acc + pri_ext;
            acs_pkg::ACS_ACC_SUB:  if (pri_take) next_acc = acc - pri_ext;
            acs_pkg::ACS_ACC_HOLD: next_acc = acc;
        endcase
        // Ready flags: setting wins over a clearing read
        next_rdy0  = pri_take || cal_done || (rdy0 && !rdy_clr);
        next_rdy1  = aux_take || cal_done || (rdy1 && !rdy_clr);
        // Range errors follow each written result
        next_err0  = pri_take ? (pri_over || pri_under) : err0;
        next_err1  = aux_take ? (aux_over || aux_under) : err1;
        // Calibration flag: set wins over mode write
        next_cal   = cal_done
                     || (cal && !(mmr_wr && is_at(mmr_addr, `ACS_MODE_OFF)));
        // Gross overrange sampled each interval, sticky
        if (!cfg[`ACS_CFG_OVR_EN])
            next_ovr = 1'b0;
        else if (tick && ovr_sync)
            next_ovr = 1'b1;
        else
            next_ovr = ovr && !gain_change;
        // Accumulator level flag
        next_athex = $signed(next_acc) > $signed(next_ath);
        // Unmasked low status raises the interrupt
        next_irq   = |(sta[7:0] & mask);
        // Power controls
        next_slow  = !next_mode[`ACS_MODE_CLKFULL];
        next_sleep = !next_mode[`ACS_MODE_REFPWR] && !ext_ref_sel;
        // Read data mux; unmapped reads zero
        next_rdata = '0;
        if (mmr_rd)
        begin
            if (is_at(mmr_addr, `ACS_STATUS_OFF))
                next_rdata = {16'h0000, sta};
            else if (is_at(mmr_addr, `ACS_MASK_OFF))
                next_rdata = {24'h000000, mask};
            else if (is_at(mmr_addr, `ACS_MODE_OFF))
                next_rdata = {24'h000000, mode};
            else if (is_at(mmr_addr, `ACS_CFG_OFF))
                next_rdata = {24'h000000, cfg};
            else if (is_at(mmr_addr, `ACS_PRI_RES_OFF))
                next_rdata = {8'h00, pri_data};
            else if (is_at(mmr_addr, `ACS_AUX_RES_OFF))
                next_rdata = {8'h00, aux_data};
            else if (is_at(mmr_addr, `ACS_TH_OFF))
                next_rdata = {8'h00, th};
            else if (is_at(mmr_addr, `ACS_THV_OFF))
                next_rdata = 32'(thv);
            else if (is_at(mmr_addr, `ACS_TCL_OFF))
                next_rdata = 32'(tcl);
            else if (is_at(mmr_addr, `ACS_ACC_OFF))
                next_rdata = acc;
            else if (is_at(mmr_addr, `ACS_ATH_OFF))
                next_rdata = ath;
        end
    end
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            mode          <= `ACS_MODE_RST;
            cfg           <= `ACS_CFG_RST;
            mask          <= `ACS_MASK_RST;
            th            <= '0;
            tcl           <= '0;
            ath           <= '0;
            acc           <= '0;
            pri_data      <= '0;
            aux_data      <= '0;
            {rdy0, rdy1}  <= 2'h0;
            {err0, err1}  <= 2'h0;
            {cal, ovr}    <= 2'h0;
            athex         <= 1'b0;
            tick_cnt      <= '0;
            mmr_rdata     <= '0;
            irq           <= 1'b0;
            conv_clk_slow <= 1'b0;
            int_ref_sleep <= 1'b0;
        end
        else
        begin
            mode          <= next_mode;
            cfg           <= next_cfg;
            mask          <= next_mask;
            th            <= next_th;
            tcl           <= next_tcl;
            ath           <= next_ath;
            acc           <= next_acc;
            pri_data      <= next_pri_data;
            aux_data      <= next_aux_data;
            rdy0          <= next_rdy0;
            rdy1          <= next_rdy1;
            err0          <= next_err0;
            err1          <= next_err1;
            cal           <= next_cal;
            ovr           <= next_ovr;
            athex         <= next_athex;
            tick_cnt      <= next_tick_cnt;
            mmr_rdata     <= next_rdata;
            irq           <= next_irq;
            conv_clk_slow <= next_slow;
            int_ref_sleep <= next_sleep;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    sequence pri_read_s;
        mmr_rd && is_at(mmr_addr, `ACS_PRI_RES_OFF);
    endsequence
    sequence quiet_s;
        !pri_take && !aux_take && !cal_done;
    endsequence
    rdy_clear_a: assert property (pri_read_s and quiet_s |=> !rdy0 && !rdy1)
        else $error("primary read did not clear ready");
    aux_clear_a: assert property (mmr_rd && is_at(mmr_addr, `ACS_AUX_RES_OFF)
        && !mode[`ACS_MODE_PRI_EN] && !aux_take && !cal_done |=> !rdy1)
        else $error("aux read did not clear ready");
    hold_data_a: assert property (rdy0 && !rdy_clr && !core_down
        |=> $stable(pri_data))
        else $error("primary result overwritten while ready");
    cal_clear_a: assert property (mmr_wr && is_at(mmr_addr, `ACS_MODE_OFF)
        && !cal_done |=> !sta[`ACS_ST_CAL])
        else $error("mode write did not clear calibration flag");
    pri_clamp_a: assert property (pri_take && pri_over |=>
        pri_data == `ACS_POS_FS && err0)
        else $error("primary overrange not clamped");
    aux_clamp_a: assert property (aux_take && aux_under |=>
        aux_data == `ACS_NEG_FS && err1)
        else $error("aux underrange not clamped");
    err_clear_a: assert property (pri_take && !pri_over && !pri_under
        |=> !err0)
        else $error("in-range result left primary error set");
    acc_flag_a: assert property (athex == ($signed(acc) > $signed(ath)))
        else $error("accumulator flag disagrees with compare");
    irq_mask_a: assert property (##1 irq == |($past(sta[7:0] & mask)))
        else $error("interrupt does not follow masked status");
    reserved_a: assert property (sta[14] == 1'b0 && sta[11:7] == 5'h00
        && sta[5] == 1'b0 && sta[2] == 1'b0)
        else $error("reserved status bit set");
endmodule

// [dv/acs_top_tb.sv]
// Bench for the converter result, compare and status block
`timescale 1ns/10ps
`include "acs_params.svh"
module acs_top_tb;
    // ----------------------------------------------------------
    // Stimulus, observed outputs and counters
    // ----------------------------------------------------------
    logic        sys_clk = 1'b0, rst_b = 1'b0;
    logic [31:0] mmr_addr = 32'h0, mmr_wdata = 32'h0, mmr_rdata, d;
    logic        mmr_wr = 1'b0, mmr_rd = 1'b0, cal_done = 1'b0;
    logic        pri_vld = 1'b0, pri_over = 1'b0, pri_under = 1'b0;
    logic        aux_vld = 1'b0, aux_over = 1'b0, aux_under = 1'b0;
    logic [23:0] pri_code = 24'h0, aux_code = 24'h0;
    logic        gross_ovr_pin = 1'b0, gain_change = 1'b0;
    logic        core_down = 1'b0, ext_ref_sel = 1'b0;
    logic        conv_clk_slow, int_ref_sleep, irq;
    int          n_errors = 0, samples_checked = 0;
    // Short overrange interval keeps the run brief
    acs_top #(.OVR_PERIOD(8)) uut (.sys_clk, .rst_b, .mmr_addr, .mmr_wr,
        .mmr_rd, .mmr_wdata, .mmr_rdata, .pri_vld, .pri_code, .pri_over,
        .pri_under, .aux_vld, .aux_code, .aux_over, .aux_under, .cal_done,
        .gross_ovr_pin, .gain_change, .core_down, .ext_ref_sel,
        .conv_clk_slow, .int_ref_sleep, .irq);
    // 50 MHz clock
    initial forever #10 sys_clk = ~sys_clk;
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        mmr_addr  <= a;
        mmr_wdata <= v;
        mmr_wr    <= 1'b1;
        @(posedge sys_clk);
        mmr_wr <= 1'b0;
    endtask
    // One-cycle read strobe, data taken the cycle after
    task automatic rd(input logic [31:0] a);
        @(posedge sys_clk);
        mmr_addr <= a;
        mmr_rd   <= 1'b1;
        @(posedge sys_clk);
        mmr_rd <= 1'b0;
        #1 d = mmr_rdata;
    endtask
    // Status read and compare
    task automatic st(input logic [31:0] exp);
        rd(`ACS_STATUS_OFF);
        chk(d, exp);
    endtask
    // One result pulse on the primary or the auxiliary channel
    task automatic res(input logic x, input logic [23:0] c,
                       input logic o, input logic u);
        @(posedge sys_clk);
        pri_vld   <= !x;
        aux_vld   <= x;
        pri_code  <= c;
        aux_code  <= c;
        pri_over  <= o;
        aux_over  <= o;
        pri_under <= u;
        aux_under <= u;
        @(posedge sys_clk);
        pri_vld <= 1'b0;
        aux_vld <= 1'b0;
    endtask
    // Reset values, clock slowing and reference sleep
    task automatic t_mode;
        st(32'h0);
        rd(`ACS_MASK_OFF);
        chk(d, 32'h0);
        wr(`ACS_MODE_OFF, 32'h01);
        repeat (2) @(posedge sys_clk);
        ext_ref_sel <= 1'b1;
        #1 chk(32'(conv_clk_slow), 32'h1);
        chk(32'(int_ref_sleep), 32'h1);
        repeat (2) @(posedge sys_clk);
        ext_ref_sel <= 1'b0;
        #1 chk(32'(int_ref_sleep), 32'h0);
        wr(`ACS_MODE_OFF, 32'hA3);
        $display("mode test done");
    endtask
    // Clamping, range errors, ready flags and held results
    task automatic t_results;
        res(1'b0, 24'h000001, 1'b1, 1'b0);
        st(32'h1001);
        rd(`ACS_PRI_RES_OFF);
        chk(d, 32'h7FFFFF);
        st(32'h1000);
        res(1'b0, 24'h000123, 1'b0, 1'b0);
        res(1'b0, 24'h000456, 1'b0, 1'b0);
        st(32'h0001);
        rd(`ACS_PRI_RES_OFF);
        chk(d, 32'h123);
        res(1'b1, 24'h000007, 1'b0, 1'b1);
        rd(`ACS_AUX_RES_OFF);
        chk(d, 32'h800000);
        st(32'h2002);
        rd(`ACS_PRI_RES_OFF);
        st(32'h2000);
        res(1'b1, 24'h000010, 1'b0, 1'b0);
        st(32'h0002);
        rd(`ACS_PRI_RES_OFF);
        $display("result test done");
    endtask
    // Masked interrupt, calibration flag, ignored status write
    task automatic t_irq_cal;
        wr(`ACS_MASK_OFF, 32'h01);
        res(1'b0, 24'h000005, 1'b0, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(irq), 32'h1);
        wr(`ACS_MASK_OFF, 32'h00);
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(irq), 32'h0);
        rd(`ACS_PRI_RES_OFF);
        @(posedge sys_clk);
        cal_done <= 1'b1;
        @(posedge sys_clk);
        cal_done <= 1'b0;
        wr(`ACS_STATUS_OFF, 32'hFFFF);
        st(32'h8003);
        wr(`ACS_MODE_OFF, 32'hA3);
        st(32'h0003);
        $display("interrupt test done");
    endtask
    // Compare, counter, accumulator, overrange, core down, aux clear
    task automatic t_cmp;
        rd(`ACS_PRI_RES_OFF);
        wr(`ACS_TH_OFF, 32'h10);
        wr(`ACS_ATH_OFF, 32'h20);
        wr(`ACS_CFG_OFF, 32'h2C);
        res(1'b0, 24'hFFFFE0, 1'b0, 1'b0);
        st(32'h0011);
        rd(`ACS_ACC_OFF);
        chk(d, 32'hFFFFFFE0);
        rd(`ACS_PRI_RES_OFF);
        res(1'b0, 24'h000050, 1'b0, 1'b0);
        st(32'h0051);
        @(posedge sys_clk);
        gross_ovr_pin <= 1'b1;
        repeat (12) @(posedge sys_clk);
        st(32'h0059);
        @(posedge sys_clk);
        gross_ovr_pin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        gain_change <= 1'b1;
        @(posedge sys_clk);
        gain_change <= 1'b0;
        core_down   <= 1'b1;
        res(1'b0, 24'h000001, 1'b0, 1'b0);
        rd(`ACS_PRI_RES_OFF);
        chk(d, 32'h1);
        @(posedge sys_clk);
        core_down <= 1'b0;
        wr(`ACS_TCL_OFF, 32'h2);
        wr(`ACS_CFG_OFF, 32'h34);
        res(1'b0, 24'h000020, 1'b0, 1'b0);
        rd(`ACS_THV_OFF);
        chk(d, 32'h1);
        rd(`ACS_PRI_RES_OFF);
        res(1'b0, 24'h000020, 1'b0, 1'b0);
        st(32'h0051);
        wr(`ACS_MODE_OFF, 32'hA2);
        res(1'b1, 24'h000020, 1'b0, 1'b0);
        rd(`ACS_AUX_RES_OFF);
        st(32'h0050);
        chk(32'(conv_clk_slow), 32'h0);
        $display("compare test done");
    endtask
    // Verdict and end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_mode();
        t_results();
        t_irq_cal();
        t_cmp();
        stop_test();
    end
endmodule
